// File: src/cacf_ctrl.sv
// Purpose: Control/status register of the programmable counter array
// Assumes: Core writes a whole byte; module events are one-cycle pulses
// Notes: Reserved bit 5 reads zero; counter is 16 bits, free running
// Function
// - Overflow flag is bit 7 of register D8, beside run bit and 5 flags.
// - Hardware sets the overflow flag when the counter wraps to zero.
// - The overflow flag requests an interrupt only while its enable is set.
// - Software may set or clear the overflow flag; hardware only sets it.
`timescale 1ns/100ps
module cacf_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire cacf_pkg::cacf_sfr_req_t sfr_req_i,
  input wire logic overflow_interrupt_enable_i,
  input wire logic [4:0] module_event_i,
  output logic [7:0] sfr_rdata_o,
  output logic counter_run_o,
  output logic [15:0] count_o,
  output logic overflow_irq_o
);
  // State and next values
  logic counter_overflow_flag;
  logic counter_run_control;
  logic [4:0] module_event_flag;
  logic [15:0] count;
  logic [7:0] rdata;
  logic irq;
  logic next_ovf;
  logic next_run;
  logic [4:0] next_mflag;
  logic [15:0] next_count;
  logic [7:0] next_rdata;
  logic next_irq;
  logic wr_hit;
  logic wrap;

  // Counter group: free-running 16-bit count, gated only by the run bit
  always_comb
  begin
    wrap = counter_run_control && (count == cacf_pkg::CNT_MAX);
    next_count = count;
    if (counter_run_control)
    begin
      next_count = 16'(count + 16'h0001);
    end
  end

  // Counter register; a stopped counter keeps its value for software
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count <= cacf_pkg::CNT_RESET;
    end
    else
    begin
      count <= next_count;
    end
  end

  // Flag group; hardware set is applied last so it wins over a clear
  always_comb
  begin
    wr_hit = sfr_req_i.wr && (sfr_req_i.addr == cacf_pkg::CTRL_ADDR);
    next_ovf = counter_overflow_flag;
    next_run = counter_run_control;
    next_mflag = module_event_flag;
    if (wr_hit)
    begin
      next_ovf = sfr_req_i.wdata[cacf_pkg::OVF_BIT];
      next_run = sfr_req_i.wdata[cacf_pkg::RUN_BIT];
      next_mflag = sfr_req_i.wdata[4:0];
    end
    if (wrap)
    begin
      next_ovf = 1'b1;
    end
    next_mflag = next_mflag | module_event_i;
    // Interrupt follows the flag in the same cycle as the read image
    next_irq = next_ovf && overflow_interrupt_enable_i;
    // Reserved bit forced low so a stray write of one never reads back
    next_rdata = {next_ovf, next_run, 1'b0, next_mflag} &
                 cacf_pkg::CTRL_RD_MASK;
  end

  // Flag registers; the read image is a copy so the output is a flop
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      counter_overflow_flag <= 1'b0;
      counter_run_control <= 1'b0;
      module_event_flag <= 5'h00;
      rdata <= cacf_pkg::CTRL_RESET;
      irq <= 1'b0;
    end
    else
    begin
      counter_overflow_flag <= next_ovf;
      counter_run_control <= next_run;
      module_event_flag <= next_mflag;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // Outputs straight from the flops
  assign sfr_rdata_o = rdata;
  assign counter_run_o = counter_run_control;
  assign count_o = count;
  assign overflow_irq_o = irq;

  // Checks on the flag and counter behaviour seen by software
  // Each property is disabled only while reset is high, so $past in the
  // first cycle after reset can see the values held during reset
  property p_wrap_sets;
    @(posedge clk_sys_i) disable iff (rst_i)
    (counter_run_control && count == 16'hFFFF) |=> counter_overflow_flag;
  endproperty
  a_wrap_sets: assert property (p_wrap_sets) else $error("wrap lost");
  property p_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
    overflow_irq_o == (counter_overflow_flag &&
      $past(overflow_interrupt_enable_i));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_hw_noclear;
    @(posedge clk_sys_i) disable iff (rst_i)
    (counter_overflow_flag && !wr_hit) |=> counter_overflow_flag;
  endproperty
  a_hw_noclear: assert property (p_hw_noclear)
    else $error("ovf dropped");
  property p_mod_sticky;
    @(posedge clk_sys_i) disable iff (rst_i)
    !wr_hit |=> ((module_event_flag & ~$past(module_event_flag)) ==
      ($past(module_event_i) & ~$past(module_event_flag)))
      && ((module_event_flag & $past(module_event_flag)) ==
      $past(module_event_flag));
  endproperty
  a_mod_sticky: assert property (p_mod_sticky) else $error("flag bad");
  property p_count_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    !counter_run_control |=> count == $past(count);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("count moved");
  property p_rdata;
    @(posedge clk_sys_i) disable iff (rst_i)
    sfr_rdata_o == {counter_overflow_flag, counter_run_control, 1'b0,
      module_event_flag};
  endproperty
  a_rdata: assert property (p_rdata) else $error("read layout");

  // A wrap and a clear in one cycle: the wrap must survive
  property p_set_wins;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wrap && wr_hit) |=> counter_overflow_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");

  // Without a wrap, a write lands as written
  property p_sw_ovf;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_hit && !wrap) |=>
      counter_overflow_flag == $past(sfr_req_i.wdata[7]);
  endproperty
  a_sw_ovf: assert property (p_sw_ovf) else $error("ovf write");

  // Nothing but a wrap or a write may move the flag
  property p_ovf_cause;
    @(posedge clk_sys_i) disable iff (rst_i)
    (!wrap && !wr_hit) |=> $stable(counter_overflow_flag);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("ovf rose");

  // Run bit follows a write to this register
  property p_run_write;
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_hit |=> counter_run_control == $past(sfr_req_i.wdata[6]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run write");

  property p_run_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    !wr_hit |=> $stable(counter_run_control);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run moved");

  // Running counter steps by one and wraps to zero by its width
  property p_count_step;
    @(posedge clk_sys_i) disable iff (rst_i)
    counter_run_control |=> count == 16'($past(count) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count step");

  // An event sets its flag even under a same-cycle clear
  property p_event_sets;
    @(posedge clk_sys_i) disable iff (rst_i)
    1'b1 |=> (module_event_flag & $past(module_event_i)) ==
      $past(module_event_i);
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event lost");

  // Main scenarios
  c_wrap: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wrap ##1 overflow_irq_o);
  c_clear: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    counter_overflow_flag ##1 !counter_overflow_flag);
  c_event: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    module_event_i[4] ##1 module_event_flag[4]);
  c_sw_set: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_hit && sfr_req_i.wdata[7]) ##1 overflow_irq_o);
  c_ignored: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    sfr_req_i.wr && !wr_hit);
endmodule : cacf_ctrl

// File: src/cacf_pkg.sv
// Purpose: Constants and types for the counter array control/status flags
// Assumes: Byte-wide special function register port, one clock
// Notes: Register sits at its printed location on the internal SFR port
package cacf_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hD8;
  localparam int OVF_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam int NUM_MOD = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RD_MASK = 8'hDF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // One SFR access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cacf_sfr_req_t;
endpackage : cacf_pkg

// File: tb/cacf_ctrl_tb.sv
// Purpose: Self-checking bench for the counter array control flags
// Assumes: One 16-bit wrap fits in the run
// Notes: Watchdog ends a run whose wrap never comes
`timescale 1ns/100ps
module cacf_ctrl_tb;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, en = 1'b1, run, irq;
  cacf_pkg::cacf_sfr_req_t req = '0;
  logic [4:0] ev = 5'h00;
  logic [7:0] rd;
  logic [15:0] cnt;
  int num_errors = 0, cmp_count = 0;
  cacf_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_req_i(req),
    .overflow_interrupt_enable_i(en), .module_event_i(ev), .sfr_rdata_o(rd),
    .counter_run_o(run), .count_o(cnt), .overflow_irq_o(irq));
  always #2.5 clk_sys_i = ~clk_sys_i;
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    num_errors += int'(s !== e);
    if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys_i) req.wr <= 1'b0;
    @(negedge clk_sys_i);
  endtask : wr
  task drv(input logic e, input logic [4:0] v);
    @(posedge clk_sys_i) en <= e;
    ev <= v;
    @(posedge clk_sys_i) ev <= 5'h00;
    @(negedge clk_sys_i);
  endtask : drv
  task stop_test(input int e);
    num_errors += e;
    $display("Checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Watchdog; a hang counts as a mismatch
  initial #(5 * 90000) stop_test(1);
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("reset", {rd, 7'h00, run}, 16'h0000);
    chk("reset_cnt", {cnt[14:0], irq}, 16'h0000);
    wr(8'hD8, 8'h40);
    chk("run", {rd, 7'h00, run}, 16'h4001);
    repeat (3) @(negedge clk_sys_i);
    chk("count", cnt, 16'h0003);
    wait (cnt === 16'hFFFF);
    repeat (2) @(negedge clk_sys_i);
    chk("wrap", {rd, 7'h00, irq}, 16'hC001);
    chk("wrap_cnt", cnt, 16'h0000);
    drv(1'b0, 5'h00);
    chk("irq_off", {rd, 7'h00, irq}, 16'hC000);
    wr(8'hD8, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    chk("clear", {rd, cnt[7:0]}, 16'h0004);
    wr(8'hD8, 8'h80);
    drv(1'b1, 5'h00);
    chk("sw_set", {rd, 7'h00, irq}, 16'h8001);
    wr(8'hD8, 8'h20);
    chk("resv", {rd, 7'h00, irq}, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      drv(1'b1, 5'h01 << i);
      chk("evt", {8'h00, rd}, 16'((2 << i) - 1));
    end
    wr(8'hD7, 8'h00);
    chk("other_addr", {8'h00, rd}, 16'h001F);
    wr(8'hD8, 8'h00);
    chk("sw_clr", {8'h00, rd}, 16'h0000);
    stop_test(0);
  end
endmodule : cacf_ctrl_tb
